// *** core/flash_host_pkg.sv ***
// Package holding constants for the byte-wide flash bus host controller.
package flash_host_pkg;
    // ==========================================
    // Bus geometry
    localparam int ADDR_W          = 19;
    localparam int DATA_W          = 8;
    localparam int SECTOR_W        = 3;
    localparam int SECTOR_LSB      = 16;
    localparam int ID_BIT          = 9;
    localparam int ID_A6_BIT       = 6;
    localparam int ID_A1_BIT       = 1;
    localparam int ID_A0_BIT       = 0;
    // ==========================================
    // Timing (20 MHz clock, 50 ns period)
    localparam int CLK_PERIOD_NS   = 50;
    localparam int ACCESS_NS       = 150;
    localparam int STROBE_NS       = 100;
    localparam int RECOVER_NS      = 50;
    localparam int ACCESS_CYC      = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC     = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 4;
    // ==========================================
    // Command kinds taken from the user port
    localparam logic [1:0] OP_READ     = 2'h0;
    localparam logic [1:0] OP_WRITE    = 2'h1;
    localparam logic [1:0] OP_ID_READ  = 2'h2;
    localparam logic [1:0] OP_PROT_CHK = 2'h3;
    // ==========================================
    // Values after reset, and the byte read back from an unprotected sector
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [DATA_W-1:0] PROT_NO  = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_RD_WAIT,
        ST_WR_PULSE,
        ST_RECOVER
    } bus_state_t;
endpackage

// *** core/cycle_timer.sv ***
// Down-counting cycle timer that flags when a programmed wait has run out.
`timescale 1ns/1ns
module cycle_timer
    import flash_host_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_load,
    input  wire logic [CNT_W-1:0] i_count,
    output logic                  o_done
);
    logic [CNT_W-1:0] count_reg;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            count_reg <= '0;
        else if (i_load)
            count_reg <= i_count;
        else if (count_reg != '0)
            count_reg <= count_reg - 4'h1;
    end

    // Done ignores the load input, since the sequencer derives its load from done and would form a loop.
    assign o_done = (count_reg == '0);
endmodule // cycle_timer

// *** core/flash_bus_host.sv ***
// Host controller that drives the byte-wide flash through its chip, output and write enable pins.
// Behaviour
// - For reads, chip select driven low first, output enable driven low one cycle later.
// - For writes, write strobe and chip select low, output enable held high.
// - Written byte is unlock data, a command, or program data.
// - Identification: qualifier on bit 9, bits 6,1 low, bit 0 from the request: low gives maker code, high part code.
// - Protect check: qualifier, bit 1 high, bits 6,0 low, sector on top bits.
`timescale 1ns/1ns
module flash_bus_host
    import flash_host_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_req_valid,
    input  wire logic [1:0]        i_req_op,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_wdata,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_rdata,
    output logic                   o_rsp_protected,
    output logic [ADDR_W-1:0]      o_address_lines,
    input  wire logic [DATA_W-1:0] i_data_lines,
    output logic [DATA_W-1:0]      o_data_lines,
    output logic                   o_data_lines_oe_n,
    output logic                   o_chip_select_n,
    output logic                   o_output_enable_n,
    output logic                   o_write_strobe_n,
    output logic                   o_id_high_voltage_qualifier
);
    // ==========================================
    // Pin input synchroniser
    logic [DATA_W-1:0] din_meta_reg;
    logic [DATA_W-1:0] din_sync_reg;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            din_meta_reg <= DATA_RST;
            din_sync_reg <= DATA_RST;
        end
        else
        begin
            din_meta_reg <= i_data_lines;
            din_sync_reg <= din_meta_reg;
        end
    end

    // ==========================================
    // Sequencer
    bus_state_t       state_reg;
    logic [1:0]       op_reg;
    logic             load;
    logic [CNT_W-1:0] load_count;
    logic             timer_done;

    cycle_timer u_timer
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (load),
        .i_count (load_count),
        .o_done  (timer_done)
    );

    // The sampled byte is two cycles old, so the read wait adds the synchroniser depth.
    always_comb
    begin
        load       = 1'b0;
        load_count = '0;
        case (state_reg)
            ST_IDLE:
            begin
                load       = i_req_valid;
                load_count = CNT_W'(1);
            end
            ST_SETUP:
            begin
                load       = timer_done;
                load_count = (op_reg == OP_WRITE) ? CNT_W'(STROBE_CYC) : CNT_W'(ACCESS_CYC + 2);
            end
            ST_RD_WAIT, ST_WR_PULSE:
            begin
                load       = timer_done;
                load_count = CNT_W'(RECOVER_CYC);
            end
            default:
            begin
                load       = 1'b0;
                load_count = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_reg <= ST_IDLE;
            op_reg    <= OP_READ;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (i_req_valid)
                    begin
                        state_reg <= ST_SETUP;
                        op_reg    <= i_req_op;
                    end
                ST_SETUP:
                    if (timer_done)
                        state_reg <= (op_reg == OP_WRITE) ? ST_WR_PULSE : ST_RD_WAIT;
                ST_RD_WAIT, ST_WR_PULSE:
                    if (timer_done)
                        state_reg <= ST_RECOVER;
                ST_RECOVER:
                    if (timer_done)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================
    // Address, qualifier and write data pins
    // Address is stable through setup, so it is valid at the later falling edge.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_address_lines             <= ADDR_RST;
            o_id_high_voltage_qualifier <= 1'b0;
            o_data_lines                <= DATA_RST;
        end
        else if (state_reg == ST_IDLE && i_req_valid)
        begin
            o_address_lines <= i_req_addr;
            o_data_lines    <= i_req_wdata;
            o_id_high_voltage_qualifier <= (i_req_op == OP_ID_READ) || (i_req_op == OP_PROT_CHK);
            if (i_req_op == OP_ID_READ)
            begin
                o_address_lines[ID_A6_BIT] <= 1'b0;
                o_address_lines[ID_A1_BIT] <= 1'b0;
            end
            else if (i_req_op == OP_PROT_CHK)
            begin
                o_address_lines[ID_A6_BIT] <= 1'b0;
                o_address_lines[ID_A1_BIT] <= 1'b1;
                o_address_lines[ID_A0_BIT] <= 1'b0;
            end
        end
        else if (state_reg == ST_IDLE)
            o_id_high_voltage_qualifier <= 1'b0;
    end

    // ==========================================
    // Control strobes
    // Data drive is held one cycle past the strobe so write data stays valid at its rising edge.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_chip_select_n   <= 1'b1;
            o_output_enable_n <= 1'b1;
            o_write_strobe_n  <= 1'b1;
            o_data_lines_oe_n <= 1'b1;
        end
        else
        begin
            o_chip_select_n   <= !(state_reg == ST_SETUP || state_reg == ST_RD_WAIT
                                   || state_reg == ST_WR_PULSE) || load && state_reg != ST_SETUP;
            o_output_enable_n <= !((state_reg == ST_RD_WAIT && !timer_done)
                                   || (state_reg == ST_SETUP && timer_done && op_reg != OP_WRITE));
            o_write_strobe_n  <= !((state_reg == ST_WR_PULSE && !timer_done)
                                   || (state_reg == ST_SETUP && timer_done && op_reg == OP_WRITE));
            o_data_lines_oe_n <= !((state_reg == ST_SETUP || state_reg == ST_WR_PULSE)
                                   && op_reg == OP_WRITE);
        end
    end

    // ==========================================
    // User answer
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_req_ready     <= 1'b0;
            o_rsp_valid     <= 1'b0;
            o_rsp_rdata     <= DATA_RST;
            o_rsp_protected <= 1'b0;
        end
        else
        begin
            o_req_ready <= (state_reg == ST_IDLE && !i_req_valid)
                           || (state_reg == ST_RECOVER && timer_done);
            o_rsp_valid <= state_reg == ST_RD_WAIT && timer_done;
            if (state_reg == ST_RD_WAIT && timer_done)
            begin
                o_rsp_rdata     <= din_sync_reg;
                o_rsp_protected <= (op_reg == OP_PROT_CHK) && (din_sync_reg != PROT_NO);
            end
        end
    end
endmodule // flash_bus_host

// *** bench/flash_dev_model.sv ***
// Behavioural model of the byte-wide sector flash seen from its pins.
`timescale 1ns/1ns
module flash_dev_model #(
    parameter logic [7:0] MAKER = 8'h5A,  // Arbitrary value.
    parameter logic [7:0] PART  = 8'h3C,  // Arbitrary value.
    parameter logic [2:0] PSEC  = 3'h5
) (
    input  wire logic [18:0] i_a,
    input  wire logic [7:0]  i_d,
    input  wire logic        i_cs_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_vid,
    output logic [7:0]       o_d
);
    // ==========================================
    // Storage and output path
    logic [7:0]  mem [int];
    logic [7:0]  val;
    logic [18:0] wr_addr;
    logic        armed    = 1'b0;
    int          wr_count = 0;
    // The address is taken when the later strobe falls, the data when the first one rises.
    always @(negedge (i_we_n | i_cs_n))
    begin
        wr_addr = i_a;
        armed   = 1'b1;
    end
    // Only a strobe that really went low counts, so the pins settling at power-up write nothing.
    always @(posedge (i_we_n | i_cs_n))
    begin
        if (armed && i_oe_n)
        begin
            mem[int'(wr_addr)] = i_d;
            wr_count++;
        end
        armed = 1'b0;
    end
    // The write count is in the list so a read of a just written address sees the new byte.
    always @(i_a or i_vid or wr_count)
    begin
        if (i_vid && i_a[1])
            val = (i_a[18:16] == PSEC) ? 8'h01 : 8'h00;
        else if (i_vid)
            val = i_a[0] ? PART : MAKER;
        else if (mem.exists(int'(i_a)))
            val = mem[int'(i_a)];
        else
            val = i_a[7:0] ^ i_a[15:8] ^ {5'h00, i_a[18:16]};
    end
    // A released bus shows the inverse rather than a stale byte, so a late sample is caught.
    assign o_d = (!i_cs_n && !i_oe_n) ? val : ~val;
endmodule  // flash_dev_model

// *** bench/flash_bus_host_checker.sv ***
// Pin protocol checker bound to the flash bus host.
`timescale 1ns/1ns
module flash_bus_host_checker (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        o_req_ready,
    input wire logic        o_rsp_valid,
    input wire logic [18:0] o_address_lines,
    input wire logic [7:0]  o_data_lines,
    input wire logic        o_data_lines_oe_n,
    input wire logic        o_chip_select_n,
    input wire logic        o_output_enable_n,
    input wire logic        o_write_strobe_n,
    input wire logic        o_id_high_voltage_qualifier
);
    // ==========================================
    // Properties
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_oe_on; $fell(o_output_enable_n); endsequence
    sequence s_access; (!o_output_enable_n)[*3] ##[1:8] o_rsp_valid; endsequence
    property p_rd_pins; !o_output_enable_n |-> !o_chip_select_n && o_write_strobe_n; endproperty
    property p_wr_pins; !o_write_strobe_n |-> !o_chip_select_n && o_output_enable_n; endproperty
    property p_no_fight; !o_data_lines_oe_n |-> o_output_enable_n; endproperty
    property p_idle; o_req_ready |-> o_chip_select_n && o_write_strobe_n; endproperty
    property p_wr_hold; !o_write_strobe_n |-> $stable(o_address_lines) && $stable(o_data_lines); endproperty
    property p_rd_time; s_oe_on |-> s_access; endproperty
    property p_id_bits; o_id_high_voltage_qualifier && !o_output_enable_n |-> !o_address_lines[6]; endproperty
    property p_we_width; $fell(o_write_strobe_n) |-> (!o_write_strobe_n)[*2] ##[1:2] o_write_strobe_n; endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("read strobes wrong");
    a_wr_pins: assert property (p_wr_pins) else $error("write strobes wrong");
    a_no_fight: assert property (p_no_fight) else $error("data bus contention");
    a_idle: assert property (p_idle) else $error("device selected while idle");
    a_wr_hold: assert property (p_wr_hold) else $error("address or data moved in write");
    a_rd_time: assert property (p_rd_time) else $error("read answer timing wrong");
    a_id_bits: assert property (p_id_bits) else $error("id address bit 6 high");
    a_we_width: assert property (p_we_width) else $error("write pulse width wrong");
endmodule  // flash_bus_host_checker
bind flash_bus_host flash_bus_host_checker u_chk (.i_clk, .i_rst, .o_req_ready, .o_rsp_valid, .o_address_lines,
    .o_data_lines, .o_data_lines_oe_n, .o_chip_select_n, .o_output_enable_n, .o_write_strobe_n,
    .o_id_high_voltage_qualifier);

// *** bench/flash_bus_host_tb.sv ***
// Self-checking testbench for the flash bus host.
`timescale 1ns/1ns
module flash_bus_host_tb;
    import flash_host_pkg::*;
    // ==========================================
    // Signals and instances
    localparam logic [7:0] MAKER = 8'h5A;  // Arbitrary value.
    localparam logic [7:0] PART  = 8'h3C;  // Arbitrary value.
    logic i_clk = 0, i_rst = 1, i_req_valid = 0, rdy, rv, prot, oe_n, cs_n, rd_n, we_n, vid;
    logic [1:0] i_req_op = 0;
    logic [ADDR_W-1:0] i_req_addr = 0, a;
    logic [DATA_W-1:0] i_req_wdata = 0, rdata, dq_o, dq_i;
    logic [7:0] sh [int];
    int num_errors = 0, check_count = 0, seed = 26;
    always #25 i_clk = ~i_clk;
    flash_bus_host u_flash_bus_host (.i_clk, .i_rst, .i_req_valid, .i_req_op, .i_req_addr, .i_req_wdata,
        .o_req_ready(rdy), .o_rsp_valid(rv), .o_rsp_rdata(rdata), .o_rsp_protected(prot),
        .o_address_lines(a), .i_data_lines(dq_i), .o_data_lines(dq_o), .o_data_lines_oe_n(oe_n),
        .o_chip_select_n(cs_n), .o_output_enable_n(rd_n), .o_write_strobe_n(we_n),
        .o_id_high_voltage_qualifier(vid));
    flash_dev_model #(.MAKER(MAKER), .PART(PART), .PSEC(3'h5)) u_flash_dev_model (.i_a(a), .i_d(dq_o),
        .i_cs_n(cs_n), .i_oe_n(rd_n), .i_we_n(we_n), .i_vid(vid), .o_d(dq_i));
    // ==========================================
    // Tasks and expectations
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] expect_rd(input logic [1:0] op, input logic [18:0] ad);
        if (op == OP_PROT_CHK)
            return (ad[18:16] == 3'h5) ? 8'h01 : 8'h00;
        if (op == OP_ID_READ)
            return ad[0] ? PART : MAKER;
        return sh.exists(int'(ad)) ? sh[int'(ad)] : ad[7:0] ^ ad[15:8] ^ {5'h00, ad[18:16]};
    endfunction
    task automatic req(input logic [1:0] op, input logic [18:0] ad, input logic [7:0] d);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 40)
        begin
            @(negedge i_clk);
            n++;
        end
        chk("ready", {7'h00, rdy}, 8'h01);
        i_req_valid = 1;
        i_req_op = op;
        i_req_addr = ad;
        i_req_wdata = d;
        @(negedge i_clk);
        i_req_valid = 0;
        i_req_op = 2'($random(seed));
        i_req_addr = 19'($random(seed));
        if (op == OP_WRITE)
            sh[int'(ad)] = d;
        else
        begin
            n = 0;
            while (rv !== 1'b1 && n < 40)
            begin
                @(negedge i_clk);
                n++;
            end
            chk("rsp_valid", {7'h00, rv}, 8'h01);
            chk("rdata", rdata, expect_rd(op, ad));
            if (op == OP_PROT_CHK)
                chk("protected", {7'h00, prot}, {7'h00, expect_rd(op, ad) != 8'h00});
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (12) @(negedge i_clk);
        chk("cs_n in reset", {7'h00, cs_n}, 8'h01);
        i_rst = 0;
        for (int s = 0; s < 8; s++)
        begin
            req(OP_READ, {3'(s), 16'h0000}, 8'h00);
            req(OP_READ, {3'(s), 16'hFFFF}, 8'h00);
            req(OP_PROT_CHK, {3'(s), 16'h0002}, 8'h00);
        end
        $display("test sectors done");
        req(OP_ID_READ, 19'h00000, 8'h00);
        req(OP_ID_READ, 19'h7FFFF, 8'h00);
        $display("test id done");
        for (int i = 0; i < 30; i++)
        begin
            logic [18:0] ad;
            logic [7:0] d;
            ad = 19'($random(seed));
            d = 8'($random(seed));
            req(OP_WRITE, ad, d);
            req(OP_READ, ad, 8'h00);
            req(2'($random(seed)), 19'($random(seed)), 8'($random(seed)));
        end
        $display("test random done");
        while (rdy !== 1'b1)
            @(negedge i_clk);
        i_rst = 1;
        repeat (2) @(negedge i_clk);
        chk("ready in reset", {7'h00, rdy}, 8'h00);
        chk("we_n in reset", {7'h00, we_n}, 8'h01);
        i_rst = 0;
        req(OP_READ, 19'h2A5C3, 8'h00);
        $display("test reset done");
        conclude();
    end
    initial
    begin
        #2000000;
        num_errors++;
        conclude();
    end
endmodule  // flash_bus_host_tb
